// file: eisc_consts.svh
// Register offsets, field positions, reset values and counts for the low-group sense control block
`ifndef EISC_CONSTS_SVH
`define EISC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define EISC_OFF_SENSE_CTRL   8'h00
`define EISC_OFF_FLAG_STATUS  8'h04
`define EISC_OFF_IRQ_STATUS   8'h08
`define EISC_OFF_IRQ_MASK     8'h0c

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define EISC_LINES            8
`define EISC_FIELD_W          2
`define EISC_RISE_BIT         1
`define EISC_FALL_BIT         0
`define EISC_SENSE_RESET      16'h0000
`define EISC_FLAG_RESET       16'h0000
`define EISC_MASK_RESET       8'h00
`define EISC_SYNC_STAGES      3

`endif

// file: eisc_pkg.sv
// Types shared by the low-group sense control block
package eisc_pkg;
    // Sense mode encoding of one 2-bit field
    typedef enum logic [1:0] {
        EISC_LOW_LEVEL = 2'h0,
        EISC_FALL_EDGE = 2'h1,
        EISC_RISE_EDGE = 2'h2,
        EISC_BOTH_EDGE = 2'h3
    } eisc_mode_t;

    typedef logic [7:0] eisc_addr_t;
    typedef logic [31:0] eisc_data_t;
endpackage

// file: eisc_if.sv
// Interface carrying sampled pin levels from the synchroniser to the register core
`timescale 1ns/10ps
interface eisc_pin_if;
    logic [7:0] level;
    logic [7:0] prev;
    modport source (output level, output prev);
    modport sink   (input level, input prev);
endinterface

// file: eisc_sync.sv
// Three-stage pin synchroniser that reports the current and previous agreed levels
`timescale 1ns/10ps
`include "eisc_consts.svh"
module eisc_sync #(
    parameter int LINES = `EISC_LINES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Raw active-low pins
    input  wire logic [LINES-1:0] pin_n,
    // Synchronised levels
    eisc_pin_if.source            pins
);
    logic [LINES-1:0] stage1;
    logic [LINES-1:0] stage2;
    logic [LINES-1:0] stage3;
    logic [LINES-1:0] agreed;

    // Stage one is read only by stage two; pins idle high after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1 <= '1;
            stage2 <= '1;
            stage3 <= '1;
        end else begin
            stage1 <= pin_n;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < LINES; i++) begin : g_agree
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    agreed[i] <= 1'b1;
                end else if (stage2[i] == stage3[i]) begin
                    agreed[i] <= stage3[i];
                end
            end
        end
    endgenerate

    // Previous sample, compared with the current one for edges
    logic [LINES-1:0] prev_q;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_q <= '1;
        end else begin
            prev_q <= agreed;
        end
    end

    assign pins.level = agreed;
    assign pins.prev  = prev_q;
endmodule // eisc_sync

// file: eisc_top.sv
// Low-group external interrupt sense control with request flags and interrupt output
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
`include "eisc_consts.svh"
module eisc_top
    import eisc_pkg::*;
#(
    parameter int LINES = `EISC_LINES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // External active-low request pins 7..0
    input  wire logic [LINES-1:0] ext_request_pin_n,
    // Register port
    input  wire eisc_pkg::eisc_addr_t addr,
    input  wire eisc_pkg::eisc_data_t wdata,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    output eisc_pkg::eisc_data_t  rdata,
    // Interrupt controller side
    output logic [LINES-1:0]      line_request,
    output logic                  irq
);
    import eisc_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    eisc_pin_if pins ();

    eisc_sync #(.LINES(LINES)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin_n   (ext_request_pin_n),
        .pins    (pins.source)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0]      low_group_sense_control;
    logic [15:0]      request_flag_status;
    logic [LINES-1:0] irq_status;
    logic [LINES-1:0] irq_mask;

    // Address decode
    wire sel_sense  = (addr == `EISC_OFF_SENSE_CTRL);
    wire sel_flag   = (addr == `EISC_OFF_FLAG_STATUS);
    wire sel_status = (addr == `EISC_OFF_IRQ_STATUS);
    wire sel_mask   = (addr == `EISC_OFF_IRQ_MASK);

    // ----------------------------------------------------------------
    // Per-line sense decode
    // ----------------------------------------------------------------
    logic [LINES-1:0] detect;
    logic [LINES-1:0] rise_sel;
    logic [LINES-1:0] fall_sel;

    // Line n uses bits 2n+1 (rise) and 2n (fall)
    genvar n;
    generate
        for (n = 0; n < LINES; n++) begin : g_line
            eisc_mode_t mode;
            wire        pin_low;
            wire        fell;
            wire        rose;
            assign rise_sel[n] = low_group_sense_control[2*n + `EISC_RISE_BIT];
            assign fall_sel[n] = low_group_sense_control[2*n + `EISC_FALL_BIT];
            assign mode        = eisc_mode_t'({rise_sel[n], fall_sel[n]});
            // Pin levels are active low; edges from successive samples
            assign pin_low = ~pins.level[n];
            assign fell    = pins.prev[n] & ~pins.level[n];
            assign rose    = ~pins.prev[n] & pins.level[n];
            // Low level, falling, rising or both
            assign detect[n] = (mode == EISC_LOW_LEVEL) ? pin_low :
                               (mode == EISC_FALL_EDGE) ? fell :
                               (mode == EISC_RISE_EDGE) ? rose :
                                                          (fell | rose);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register writes and flag updates
    // ----------------------------------------------------------------
    wire [15:0] flag_set   = {{(16-LINES){1'b0}}, detect};
    // Writing 0 clears a flag; a detection in the same cycle wins
    wire [15:0] flag_clear = (wr_en && sel_flag) ? ~wdata[15:0] : 16'h0000;
    wire [15:0] next_flag  = (request_flag_status & ~flag_clear) | flag_set;

    // Reading the status register clears it; a new event wins
    wire [LINES-1:0] status_clear = (rd_en && sel_status) ? {LINES{1'b1}} : '0;
    wire [LINES-1:0] next_status  = (irq_status & ~status_clear) | detect;

    // Sense control, fully read/write
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            low_group_sense_control <= `EISC_SENSE_RESET;
        end else if (wr_en && sel_sense) begin
            low_group_sense_control <= wdata[15:0];
        end
    end

    // Request flags, lines above the low group stay zero here
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            request_flag_status <= `EISC_FLAG_RESET;
        end else begin
            request_flag_status <= next_flag;
        end
    end

    // Interrupt status and mask
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_status <= '0;
            irq_mask   <= `EISC_MASK_RESET;
        end else begin
            irq_status <= next_status;
            if (wr_en && sel_mask) begin
                irq_mask <= wdata[LINES-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe; unmapped reads give zero
    // ----------------------------------------------------------------
    wire [31:0] next_rdata =
        !rd_en     ? 32'h0000_0000 :
        sel_sense  ? {16'h0000, low_group_sense_control} :
        sel_flag   ? {16'h0000, request_flag_status} :
        sel_status ? {{(32-LINES){1'b0}}, irq_status} :
        sel_mask   ? {{(32-LINES){1'b0}}, irq_mask} :
                     32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Flags go straight to the controller; irq is a level
    assign line_request = request_flag_status[LINES-1:0];
    assign irq          = |(irq_status & irq_mask);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Checker view of pins and modes, rebuilt apart from the detect mux but from the same rise_sel and
    // fall_sel, so that a slip in the mux shows up here; the field offsets are checked by the field-map asserts
    wire [LINES-1:0] chk_low    = ~pins.level;
    wire [LINES-1:0] chk_fall   = pins.prev & ~pins.level;
    wire [LINES-1:0] chk_rise   = ~pins.prev & pins.level;
    wire [LINES-1:0] chk_edge   = chk_fall | chk_rise;
    wire [LINES-1:0] level_mode = ~rise_sel & ~fall_sel;
    wire [LINES-1:0] fall_mode  = ~rise_sel & fall_sel;
    wire [LINES-1:0] rise_mode  = rise_sel & ~fall_sel;
    wire [LINES-1:0] both_mode  = rise_sel & fall_sel;
    wire [LINES-1:0] want_level = level_mode & chk_low;
    wire [LINES-1:0] want_fall  = fall_mode & chk_fall;
    wire [LINES-1:0] want_rise  = rise_mode & chk_rise;
    wire [LINES-1:0] want_both  = both_mode & chk_edge;
    wire [LINES-1:0] flags_low  = request_flag_status[LINES-1:0];
    // Any request that the line's mode does not call for
    wire [LINES-1:0] stray      = detect & ~(want_level | want_fall | want_rise | want_both);
    // No register decodes the address
    wire             sel_none   = !(sel_sense || sel_flag || sel_status || sel_mask);

    // Field placement
    a_rise_field_map: assert property (
        rise_sel[7:0] == {low_group_sense_control[15], low_group_sense_control[13], low_group_sense_control[11],
                          low_group_sense_control[9], low_group_sense_control[7], low_group_sense_control[5],
                          low_group_sense_control[3], low_group_sense_control[1]})
        else $error("rise selects are not on the odd sense bits");

    a_fall_field_map: assert property (
        fall_sel[7:0] == {low_group_sense_control[14], low_group_sense_control[12], low_group_sense_control[10],
                          low_group_sense_control[8], low_group_sense_control[6], low_group_sense_control[4],
                          low_group_sense_control[2], low_group_sense_control[0]})
        else $error("fall selects are not on the even sense bits");

    // Sense decode
    a_low_level_req: assert property (
        want_level != '0 |=> (flags_low & $past(want_level)) == $past(want_level))
        else $error("low level did not set the line flag");

    a_fall_edge_req: assert property (
        want_fall != '0 |=> (flags_low & $past(want_fall)) == $past(want_fall))
        else $error("falling edge did not set the line flag");

    a_rise_edge_req: assert property (
        want_rise != '0 |=> (flags_low & $past(want_rise)) == $past(want_rise))
        else $error("rising edge did not set the line flag");

    a_both_edge_req: assert property (
        want_both != '0 |=> (flags_low & $past(want_both)) == $past(want_both))
        else $error("transition did not set the line flag");

    a_rise_no_fall: assert property (
        (rise_mode & ~chk_rise & detect) == '0)
        else $error("rise-only line raised a request without a rising edge");

    a_no_stray_req: assert property (
        stray == '0)
        else $error("a line requested outside its sense mode");

    // Request flags
    a_flag_sticky: assert property (
        (request_flag_status[2] && !(wr_en && sel_flag)) |=> request_flag_status[2])
        else $error("flag 2 dropped without a clearing write");

    a_flag_write_clear: assert property (
        (wr_en && sel_flag && detect == '0) |=> (request_flag_status & ~$past(wdata[15:0])) == 16'h0000)
        else $error("writing zero did not clear a request flag");

    a_flag_write_one: assert property (
        (wr_en && sel_flag && wdata[15:0] == 16'hffff) |=> (request_flag_status & $past(request_flag_status)) == $past(request_flag_status))
        else $error("writing one cleared a request flag");

    a_upper_zero: assert property (
        request_flag_status[15:8] == 8'h00)
        else $error("upper flags set in the low-group block");

    // Interrupt status, mask and level
    a_event_sets_status: assert property (
        detect != '0 |=> (irq_status & $past(detect)) == $past(detect))
        else $error("a request did not set its status bit");

    a_status_sticky: assert property (
        !(rd_en && sel_status) |=> (irq_status & $past(irq_status)) == $past(irq_status))
        else $error("status bit dropped without a read");

    a_status_read_clear: assert property (
        (rd_en && sel_status && detect == '0) |=> irq_status == '0)
        else $error("status read did not clear the status");

    a_irq_level: assert property (
        ((detect & irq_mask) != '0 && !(wr_en && sel_mask)) |=> irq)
        else $error("unmasked request did not raise irq");

    a_mask_write: assert property (
        (wr_en && sel_mask) |=> irq_mask == $past(wdata[LINES-1:0]))
        else $error("mask did not take the written value");

    // Register port
    a_sense_write_held: assert property (
        (wr_en && sel_sense) |=> (low_group_sense_control == $past(wdata[15:0])))
        else $error("sense control did not take the written value");

    a_sense_quiet: assert property (
        !(wr_en && sel_sense) |=> $stable(low_group_sense_control))
        else $error("sense control changed without a write");

    a_read_latency: assert property (
        (rd_en && sel_sense) |=> (rdata[15:0] == $past(low_group_sense_control)))
        else $error("sense control read returned the wrong value");

    a_read_flag_data: assert property (
        (rd_en && sel_flag) |=> rdata == {16'h0000, $past(request_flag_status)})
        else $error("flag read returned the wrong value");

    a_read_status_data: assert property (
        (rd_en && sel_status) |=> rdata == {{(32-LINES){1'b0}}, $past(irq_status)})
        else $error("status read returned the wrong value");

    a_read_mask_data: assert property (
        (rd_en && sel_mask) |=> rdata == {{(32-LINES){1'b0}}, $past(irq_mask)})
        else $error("mask read returned the wrong value");

    a_read_unmapped: assert property (
        (rd_en && sel_none) |=> rdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    a_rdata_idle: assert property (
        !rd_en |=> rdata == 32'h0000_0000)
        else $error("read data stood without a read");

    // Main scenarios
    c_fall_mode: cover property (wr_en && sel_sense && wdata[1:0] == 2'h1);
    c_both_edge: cover property (detect[4] && low_group_sense_control[9:8] == 2'h3);
    c_irq_raised: cover property (!irq ##1 irq);
    c_set_and_clear: cover property (wr_en && sel_flag && |detect);
    c_level_reset: cover property (wr_en && sel_flag && |(detect & level_mode));
endmodule // eisc_top

// file: eisc_pin_model.sv
// Board-side model driving the eight active-low external request pins
`timescale 1ns/10ps
module eisc_pin_model (
    // Clock
    input  wire logic  clk,
    // Pins toward the block
    output logic [7:0] pin_n
);
    // Board pull-ups hold every line inactive high until a device pulls it
    initial pin_n = 8'hff;

    // Change one line just after an edge so no change lands on the sampling edge
    task automatic drive(input int n, input logic lvl);
        @(posedge clk);
        pin_n[n] <= lvl;
    endtask
endmodule // eisc_pin_model

// file: tb_top.sv
// Self-checking bench for the low-group external request sense block
`timescale 1ns/10ps
`include "eisc_consts.svh"
module tb_top;
    import eisc_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic        clk          = 1'b0;
    logic        reset_n      = 1'b0;
    logic [7:0]  pin_n;
    eisc_addr_t  addr         = 8'h00;
    eisc_data_t  wdata        = 32'h0;
    logic        wr_en        = 1'b0;
    logic        rd_en        = 1'b0;
    eisc_data_t  rdata;
    logic [7:0]  line_request;
    logic        irq;
    int          failures     = 0;
    int          n_tests      = 0;
    int          cycles       = 0;
    eisc_data_t  val;
    logic [15:0] sense;

    eisc_pin_model pins (.clk(clk), .pin_n(pin_n));
    eisc_top dut (.clk(clk), .reset_n(reset_n), .ext_request_pin_n(pin_n), .addr(addr), .wdata(wdata),
                  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .line_request(line_request), .irq(irq));

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard, more than ten times the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input eisc_addr_t a, input eisc_data_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input eisc_addr_t a, output eisc_data_t d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Eight cycles covers the five-cycle pin-to-flag latency
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        // Register reset value, read/write and unmapped space
        rd(`EISC_OFF_SENSE_CTRL, val);
        check("sense reset", val, 32'h0);
        wr(`EISC_OFF_SENSE_CTRL, 32'h0000a5c3);
        rd(`EISC_OFF_SENSE_CTRL, val);
        check("sense rw", val, 32'h0000a5c3);
        @(negedge clk);
        check("rdata after", rdata, 32'h0);
        rd(8'h10, val);
        check("unmapped read", val, 32'h0);
        $display("test registers done");
        // Field placement: only line n rises-sensitive, the rest falling-sensitive
        for (int n = 0; n < 8; n++) begin
            sense = 16'h5555;
            sense[2*n +: 2] = 2'b10;
            wr(`EISC_OFF_SENSE_CTRL, {16'h0, sense});
            wr(`EISC_OFF_FLAG_STATUS, 32'h0);
            pins.drive(n, 1'b0);
            settle();
            rd(`EISC_OFF_FLAG_STATUS, val);
            check("fall ignored", val, 32'h0);
            pins.drive(n, 1'b1);
            settle();
            rd(`EISC_OFF_FLAG_STATUS, val);
            check("rise flag", val, 32'h1 << n);
            check("line request", {24'h0, line_request}, 32'h1 << n);
            wr(`EISC_OFF_FLAG_STATUS, 32'hffff);
            rd(`EISC_OFF_FLAG_STATUS, val);
            check("ones keep flag", val, 32'h1 << n);
        end
        $display("test field placement done");
        // All four modes on line 3; level mode re-sets the flag while the pin stays low
        for (int m = 0; m < 4; m++) begin
            wr(`EISC_OFF_SENSE_CTRL, 32'(m) << 6);
            wr(`EISC_OFF_FLAG_STATUS, 32'h0);
            pins.drive(3, 1'b0);
            settle();
            rd(`EISC_OFF_FLAG_STATUS, val);
            check("after fall", val, (m != 2) ? 32'h8 : 32'h0);
            wr(`EISC_OFF_FLAG_STATUS, 32'h0);
            pins.drive(3, 1'b1);
            settle();
            rd(`EISC_OFF_FLAG_STATUS, val);
            check("after rise", val, (m != 1) ? 32'h8 : 32'h0);
        end
        $display("test sense modes done");
        // Sticky status, mask and the level interrupt
        rd(`EISC_OFF_IRQ_STATUS, val);
        check("status all lines", val, 32'hff);
        rd(`EISC_OFF_IRQ_STATUS, val);
        check("status cleared", val, 32'h0);
        wr(`EISC_OFF_SENSE_CTRL, 32'h40);
        pins.drive(3, 1'b0);
        settle();
        @(negedge clk);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(`EISC_OFF_IRQ_MASK, 32'h8);
        @(negedge clk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        rd(`EISC_OFF_IRQ_MASK, val);
        check("mask rw", val, 32'h8);
        rd(`EISC_OFF_IRQ_STATUS, val);
        check("status line 3", val, 32'h8);
        check("irq after read", {31'h0, irq}, 32'h0);
        pins.drive(3, 1'b1);
        settle();
        @(negedge clk);
        check("falling only", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
        complete_run();
    end
endmodule // tb_top
